// ### include/clm_defines.svh
// constants for the consumable life monitor
`ifndef CLM_DEFINES_SVH
`define CLM_DEFINES_SVH

`define CLM_CLK_KHZ          25000
`define CLM_STUCK_MS         2300
`define CLM_BLOW_MS          10

`define CLM_RUN_W            5
`define CLM_LOW_RUN          5'h14
`define CLM_FULL_RUN         5'h0a

`define CLM_PRD_W            26
`define CLM_PRD_NUM_W        4
`define CLM_STUCK_PERIODS    4'hf
`define CLM_BLOW_W           18

`define CLM_TMR_W            24
`define CLM_CONTACT_LOW_CYC  24'h2625a0

`define CLM_CNT_W            16
`define CLM_DOT_W            16
`define CLM_ACC_W            24
`define CLM_DOTS_PER_PAGE    24'h06a000

`define CLM_USED_AT_LOW      16'h2cec
`define CLM_USED_MSG         16'h2ee0
`define CLM_USED_EMPTY       16'h30d4

`define CLM_DRUM_EOL         16'h4e20
`define CLM_BELT_EOL         16'hea60
`define CLM_FUSER_EOL        16'hea60

`define CLM_UNITS            3
`define CLM_U_DRUM           0
`define CLM_U_BELT           1
`define CLM_U_FUSER          2

`endif

// ### include/clm_pkg.sv
// types and shared arithmetic of the consumable life monitor
`include "clm_defines.svh"

package clm_pkg;

  typedef enum logic [1:0] {
    clm_tn_unknown,
    clm_tn_full,
    clm_tn_low,
    clm_tn_empty
  } clm_toner_t;

  typedef enum logic [1:0] {
    clm_ck_idle,
    clm_ck_judge,
    clm_ck_blow
  } clm_chk_t;

  typedef struct packed {
    logic [`CLM_TMR_W-1:0] len;
    logic                  contact_d;
    logic                  vld;
    logic                  low;
  } clm_tmr_st_t;

  typedef struct packed {
    logic [`CLM_CNT_W-1:0] cnt;
    logic                  warn;
  } clm_life_st_t;

  typedef struct packed {
    clm_toner_t                toner;
    logic [`CLM_RUN_W-1:0]     low_run;
    logic [`CLM_RUN_W-1:0]     full_run;
    logic [`CLM_ACC_W-1:0]     dot_acc;
    logic [`CLM_CNT_W-1:0]     used;
    logic                      used_wr;
    logic                      low_o;
    logic                      msg_o;
    logic                      empty_o;
    logic                      sens_d;
    logic [`CLM_PRD_W-1:0]     prd_cnt;
    logic [`CLM_PRD_NUM_W-1:0] prd_num;
    logic                      alarm;
    clm_chk_t                  chk;
    logic [`CLM_BLOW_W-1:0]    blow_cnt;
    logic [`CLM_UNITS-1:0]     unit_new;
    logic [`CLM_UNITS-1:0]     fuse_blow;
    logic                      cover_d;
    logic                      por;
  } clm_mon_st_t;

  function automatic logic [`CLM_CNT_W-1:0] clm_sat_inc(
    input logic [`CLM_CNT_W-1:0] v
  );
    return (&v) ? v : v + 1'b1;
  endfunction : clm_sat_inc

  function automatic logic [`CLM_RUN_W-1:0] clm_run_inc(
    input logic [`CLM_RUN_W-1:0] v,
    input logic [`CLM_RUN_W-1:0] lim
  );
    return (v >= lim) ? lim : v + 1'b1;
  endfunction : clm_run_inc

endpackage : clm_pkg

// ### hdl/clm_contact_timer.sv
// contact time measurement and sample classification of the toner sensor
`timescale 1ns/100ps
`default_nettype none
`include "clm_defines.svh"

module clm_contact_timer #(
  parameter logic [`CLM_TMR_W-1:0] LOW_CYC = `CLM_CONTACT_LOW_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic contact,
  input  wire logic sample_en,
  output logic      smp_vld,
  output logic      smp_low
);

  clm_pkg::clm_tmr_st_t s_r;
  clm_pkg::clm_tmr_st_t s_nxt;

  always_comb
  begin
    s_nxt           = s_r;
    s_nxt.vld       = 1'b0;
    s_nxt.contact_d = contact;
    // timer restarts at each new contact and saturates
    if (contact && !s_r.contact_d)
    begin
      s_nxt.len = '0;
    end
    else if (contact && !(&s_r.len))
    begin
      s_nxt.len = s_r.len + 1'b1;
    end
    // a sample ends with the contact; none while the drum stands
    if (!contact && s_r.contact_d && sample_en)
    begin
      s_nxt.vld = 1'b1;
      s_nxt.low = (s_r.len >= LOW_CYC);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign smp_vld = s_r.vld;
  assign smp_low = s_r.low;

endmodule : clm_contact_timer
`default_nettype wire

// ### hdl/clm_life_ctr.sv
// saturating life counter with sticky end-of-life warning
`timescale 1ns/100ps
`default_nettype none
`include "clm_defines.svh"

module clm_life_ctr #(
  parameter logic [`CLM_CNT_W-1:0] EOL = `CLM_BELT_EOL
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  inc,
  input  wire logic                  clr,
  output logic [`CLM_CNT_W-1:0]      count,
  output logic                       warn
);

  clm_pkg::clm_life_st_t s_r;
  clm_pkg::clm_life_st_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    // a new unit wipes the count; an increment in that cycle is dropped
    if (clr)
    begin
      s_nxt.cnt = '0;
    end
    else if (inc)
    begin
      s_nxt.cnt = clm_pkg::clm_sat_inc(s_r.cnt);
    end
    // warning only informs, it never blocks printing
    s_nxt.warn = !clr && (s_r.warn || (s_nxt.cnt >= EOL));
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign count = s_r.cnt;
  assign warn  = s_r.warn;

endmodule : clm_life_ctr
`default_nettype wire

// ### hdl/clm_monitor.sv
// consumable life monitor: toner level, toner use and unit life
//
// Functional notes
// - long magnet contact means low sample
// - twenty successive low samples set toner low
// - low message after 500 page-equivalents more
// - ten successive full samples clear toner low
// - sensor unchanged beyond 15 periods raises alarm
// - no sampling, stuck-sensor period count held while drum stopped
// - accumulate printed dots into toner use total
// - accumulate only once a first toner verdict is known
// - toner low forces use to 92% level
// - 1K page-equivalents after low: empty, stop
// - conducting fuse means unit is new
// - judge units at power-on and cover close
// - new unit: clear life count, blow fuse
// - drum counts page-lengths, warns at 20K
// - belt counts pages, warns at 60K
// - fuser counts pages, warns at end-of-life
// - toner low ends toner cartridge life
`timescale 1ns/100ps
`default_nettype none
`include "clm_defines.svh"

module clm_monitor #(
  parameter logic [`CLM_PRD_W-1:0]  STUCK_PERIOD_CYC =
    `CLM_PRD_W'(`CLM_STUCK_MS * `CLM_CLK_KHZ),
  parameter logic [`CLM_BLOW_W-1:0] BLOW_CYC =
    `CLM_BLOW_W'(`CLM_BLOW_MS * `CLM_CLK_KHZ),
  parameter logic [`CLM_TMR_W-1:0]  CONTACT_LOW_CYC =
    `CLM_CONTACT_LOW_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  toner_contact,
  input  wire logic                  drum_running,
  input  wire logic                  cover_closed,
  input  wire logic [`CLM_UNITS-1:0] unit_fuse_ok,
  input  wire logic                  drum_page_tick,
  input  wire logic                  page_passed,
  input  wire logic                  dot_valid,
  input  wire logic [`CLM_DOT_W-1:0] dot_count,
  input  wire logic                  nvm_load,
  input  wire logic [`CLM_CNT_W-1:0] nvm_used_in,
  output logic                       toner_low,
  output logic                       toner_low_msg,
  output logic                       toner_empty,
  output logic                       toner_sensor_alarm,
  output logic [`CLM_CNT_W-1:0]      toner_used,
  output logic                       toner_used_wr,
  output logic [`CLM_UNITS-1:0]      unit_new,
  output logic [`CLM_UNITS-1:0]      fuse_blow,
  output logic [`CLM_CNT_W-1:0]      drum_life,
  output logic [`CLM_CNT_W-1:0]      belt_life,
  output logic [`CLM_CNT_W-1:0]      fuser_life,
  output logic                       drum_warn,
  output logic                       belt_warn,
  output logic                       fuser_warn
);

  clm_pkg::clm_mon_st_t       s_r;
  clm_pkg::clm_mon_st_t       s_nxt;
  logic                       smp_vld;
  logic                       smp_low;
  logic [`CLM_ACC_W-1:0]      acc_sum;
  logic [`CLM_UNITS-1:0]      life_clr;

  clm_contact_timer #(
    .LOW_CYC   (CONTACT_LOW_CYC)
  ) u_timer (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .contact   (toner_contact),
    .sample_en (drum_running),
    .smp_vld   (smp_vld),
    .smp_low   (smp_low)
  );

  // counters clear at the end of the judging cycle, on the same edge that starts the fuse blow
  assign life_clr = (s_r.chk == clm_pkg::clm_ck_judge) ?
                    unit_fuse_ok : '0;

  clm_life_ctr #(
    .EOL     (`CLM_DRUM_EOL)
  ) u_drum (
    .sys_clk (sys_clk),
    .rst     (rst),
    .inc     (drum_page_tick),
    .clr     (life_clr[`CLM_U_DRUM]),
    .count   (drum_life),
    .warn    (drum_warn)
  );

  clm_life_ctr #(
    .EOL     (`CLM_BELT_EOL)
  ) u_belt (
    .sys_clk (sys_clk),
    .rst     (rst),
    .inc     (page_passed),
    .clr     (life_clr[`CLM_U_BELT]),
    .count   (belt_life),
    .warn    (belt_warn)
  );

  clm_life_ctr #(
    .EOL     (`CLM_FUSER_EOL)
  ) u_fuser (
    .sys_clk (sys_clk),
    .rst     (rst),
    .inc     (page_passed),
    .clr     (life_clr[`CLM_U_FUSER]),
    .count   (fuser_life),
    .warn    (fuser_warn)
  );

  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.used_wr = 1'b0;
    s_nxt.sens_d  = toner_contact;
    s_nxt.cover_d = cover_closed;
    acc_sum       = s_r.dot_acc + `CLM_ACC_W'(dot_count);

    // stuck sensor watch; a standing drum never moves the bar, so the
    // period count pauses rather than raising a false alarm
    if (toner_contact != s_r.sens_d)
    begin
      s_nxt.prd_cnt = '0;
      s_nxt.prd_num = '0;
      s_nxt.alarm   = 1'b0;
    end
    else if (drum_running)
    begin
      if (s_r.prd_cnt == STUCK_PERIOD_CYC - 1'b1)
      begin
        s_nxt.prd_cnt = '0;
        if (s_r.prd_num == `CLM_STUCK_PERIODS)
        begin
          s_nxt.alarm = 1'b1;
        end
        else
        begin
          s_nxt.prd_num = s_r.prd_num + 1'b1;
        end
      end
      else
      begin
        s_nxt.prd_cnt = s_r.prd_cnt + 1'b1;
      end
    end

    // dot accumulation in page-equivalents of 5% coverage
    if (dot_valid && (s_r.toner != clm_pkg::clm_tn_unknown))
    begin
      if (acc_sum >= `CLM_DOTS_PER_PAGE)
      begin
        s_nxt.dot_acc = acc_sum - `CLM_DOTS_PER_PAGE;
        s_nxt.used    = clm_pkg::clm_sat_inc(s_r.used);
        s_nxt.used_wr = 1'b1;
      end
      else
      begin
        s_nxt.dot_acc = acc_sum;
      end
    end

    // restore of the stored total after power-on
    if (nvm_load)
    begin
      s_nxt.used = nvm_used_in;
    end

    // consecutive sample runs; only sampled while the drum turns
    if (smp_vld)
    begin
      if (smp_low)
      begin
        s_nxt.low_run  = clm_pkg::clm_run_inc(s_r.low_run,
                                              `CLM_LOW_RUN);
        s_nxt.full_run = '0;
      end
      else
      begin
        s_nxt.full_run = clm_pkg::clm_run_inc(s_r.full_run,
                                              `CLM_FULL_RUN);
        s_nxt.low_run  = '0;
      end
    end

    unique case (s_r.toner)
      clm_pkg::clm_tn_unknown,
      clm_pkg::clm_tn_full:
      begin
        if (s_nxt.low_run == `CLM_LOW_RUN)
        begin
          s_nxt.toner   = clm_pkg::clm_tn_low;
          s_nxt.used    = `CLM_USED_AT_LOW;
          s_nxt.used_wr = 1'b1;
        end
        else if ((s_r.toner == clm_pkg::clm_tn_unknown) &&
                 (s_nxt.full_run == `CLM_FULL_RUN))
        begin
          // first verdict after power-on keeps the stored total
          s_nxt.toner = clm_pkg::clm_tn_full;
        end
      end
      clm_pkg::clm_tn_low,
      clm_pkg::clm_tn_empty:
      begin
        if (s_nxt.full_run == `CLM_FULL_RUN)
        begin
          // a fresh cartridge: use restarts from nothing
          s_nxt.toner   = clm_pkg::clm_tn_full;
          s_nxt.used    = '0;
          s_nxt.dot_acc = '0;
          s_nxt.used_wr = 1'b1;
        end
        else if ((s_r.toner == clm_pkg::clm_tn_low) &&
                 (s_nxt.used >= `CLM_USED_EMPTY))
        begin
          s_nxt.toner = clm_pkg::clm_tn_empty;
        end
      end
    endcase

    // low also marks the toner cartridge as spent
    s_nxt.low_o   = (s_nxt.toner == clm_pkg::clm_tn_low) ||
                    (s_nxt.toner == clm_pkg::clm_tn_empty);
    s_nxt.empty_o = (s_nxt.toner == clm_pkg::clm_tn_empty);
    s_nxt.msg_o   = s_nxt.low_o &&
                    (s_nxt.used >= `CLM_USED_MSG);

    // new-or-used judgement of the replaceable units
    unique case (s_r.chk)
      clm_pkg::clm_ck_idle:
      begin
        if (s_r.por || (cover_closed && !s_r.cover_d))
        begin
          s_nxt.chk = clm_pkg::clm_ck_judge;
          s_nxt.por = 1'b0;
        end
      end
      clm_pkg::clm_ck_judge:
      begin
        s_nxt.unit_new = unit_fuse_ok;
        if (|unit_fuse_ok)
        begin
          s_nxt.chk       = clm_pkg::clm_ck_blow;
          s_nxt.fuse_blow = unit_fuse_ok;
          s_nxt.blow_cnt  = '0;
        end
        else
        begin
          s_nxt.chk = clm_pkg::clm_ck_idle;
        end
      end
      clm_pkg::clm_ck_blow:
      begin
        // a cover close during the pulse is not queued
        if (s_r.blow_cnt == BLOW_CYC - 1'b1)
        begin
          s_nxt.fuse_blow = '0;
          s_nxt.chk       = clm_pkg::clm_ck_idle;
        end
        else
        begin
          s_nxt.blow_cnt = s_r.blow_cnt + 1'b1;
        end
      end
      default:
      begin
        s_nxt.chk       = clm_pkg::clm_ck_idle;
        s_nxt.fuse_blow = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_r     <= '0;
      s_r.por <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign toner_low          = s_r.low_o;
  assign toner_low_msg      = s_r.msg_o;
  assign toner_empty        = s_r.empty_o;
  assign toner_sensor_alarm = s_r.alarm;
  assign toner_used         = s_r.used;
  assign toner_used_wr      = s_r.used_wr;
  assign unit_new           = s_r.unit_new;
  assign fuse_blow          = s_r.fuse_blow;

endmodule : clm_monitor
`default_nettype wire

// ### dv/clm_monitor_properties.sv
// concurrent checks on the consumable life monitor ports
`timescale 1ns/100ps
`default_nettype none
`include "clm_defines.svh"

module clm_monitor_properties #(
  parameter logic [`CLM_BLOW_W-1:0] BLOW_CYC = 18'h00005
) (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire logic                  toner_contact,
  input wire logic                  toner_low,
  input wire logic                  toner_low_msg,
  input wire logic                  toner_empty,
  input wire logic                  toner_sensor_alarm,
  input wire logic [`CLM_CNT_W-1:0] toner_used,
  input wire logic                  toner_used_wr,
  input wire logic                  nvm_load,
  input wire logic [`CLM_UNITS-1:0] unit_new,
  input wire logic [`CLM_UNITS-1:0] fuse_blow,
  input wire logic [`CLM_CNT_W-1:0] drum_life,
  input wire logic [`CLM_CNT_W-1:0] belt_life,
  input wire logic [`CLM_CNT_W-1:0] fuser_life,
  input wire logic                  drum_warn,
  input wire logic                  belt_warn,
  input wire logic                  fuser_warn
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // length of the current blow pulse, kept until the pulse ends
  logic [`CLM_BLOW_W-1:0] blow_len_r;
  always_ff @(posedge sys_clk)
  begin
    blow_len_r <= (|fuse_blow) ? blow_len_r + 1'b1 : '0;
  end

  a_empty_means_low: assert property (toner_empty |-> toner_low)
    else $error("toner empty without toner low");
  a_msg_after_use: assert property (toner_low_msg |->
    toner_used >= `CLM_USED_MSG || $past(toner_used) >= `CLM_USED_MSG)
    else $error("low message before use threshold");
  a_empty_at_cap: assert property (toner_empty |->
    toner_used >= `CLM_USED_EMPTY || $past(toner_used) >= `CLM_USED_EMPTY)
    else $error("toner empty before capacity");
  a_low_forces_use: assert property ($rose(toner_low) |->
    ##[0:2] toner_used == `CLM_USED_AT_LOW)
    else $error("use total not forced on toner low");
  // a restore from storage is the only silent change of the use total
  a_used_wr_mark: assert property ($changed(toner_used) &&
    !$past(nvm_load) |-> toner_used_wr)
    else $error("use total changed without write pulse");
  a_blow_new_mask: assert property (|fuse_blow |->
    fuse_blow == unit_new)
    else $error("fuse blow drive differs from new units");
  a_blow_pulse_len: assert property ($fell(|fuse_blow) |->
    blow_len_r == BLOW_CYC)
    else $error("fuse blow pulse length wrong");
  // a clear lands on the same edge as the new-unit mark, so a wrap is caught
  a_drum_step_one: assert property ($changed(drum_life) |->
    (drum_life == $past(drum_life) + 16'h0001 &&
     $past(drum_life) != 16'hffff) ||
    (drum_life == 16'h0000 && unit_new[`CLM_U_DRUM]))
    else $error("drum life stepped wrongly");
  a_belt_step_one: assert property ($changed(belt_life) |->
    (belt_life == $past(belt_life) + 16'h0001 &&
     $past(belt_life) != 16'hffff) ||
    (belt_life == 16'h0000 && unit_new[`CLM_U_BELT]))
    else $error("belt life stepped wrongly");
  a_drum_warn_eol: assert property (drum_life >= `CLM_DRUM_EOL |->
    ##[0:1] drum_warn)
    else $error("drum warning missing");
  a_belt_warn_eol: assert property (belt_life >= `CLM_BELT_EOL |->
    ##[0:1] belt_warn)
    else $error("belt warning missing");
  a_fuser_warn_eol: assert property (fuser_life >= `CLM_FUSER_EOL |->
    ##[0:1] fuser_warn)
    else $error("fuser warning missing");
  a_warn_held: assert property ($fell(belt_warn) |->
    belt_life == 16'h0000)
    else $error("belt warning dropped without clear");
  a_alarm_clears: assert property ($changed(toner_contact) |->
    ##[1:3] !toner_sensor_alarm)
    else $error("alarm kept after sensor change");
endmodule : clm_monitor_properties

bind clm_monitor clm_monitor_properties #(.BLOW_CYC(BLOW_CYC)) u_clm_props (
  .sys_clk(sys_clk), .rst(rst), .toner_contact(toner_contact),
  .toner_low(toner_low), .toner_low_msg(toner_low_msg),
  .toner_empty(toner_empty), .toner_sensor_alarm(toner_sensor_alarm),
  .toner_used(toner_used), .toner_used_wr(toner_used_wr),
  .nvm_load(nvm_load), .unit_new(unit_new), .fuse_blow(fuse_blow),
  .drum_life(drum_life), .belt_life(belt_life), .fuser_life(fuser_life),
  .drum_warn(drum_warn), .belt_warn(belt_warn), .fuser_warn(fuser_warn)
);
`default_nettype wire

// ### dv/clm_sensor_model.sv
// toner sensor model: one magnet contact of a commanded length
`timescale 1ns/100ps
`default_nettype none

module clm_sensor_model (
  input  wire logic       sys_clk,
  input  wire logic       go,
  input  wire logic [7:0] len,
  output logic            contact
);
  logic [7:0] left_r = 8'h00;
  always_ff @(posedge sys_clk)
  begin
    if (go)
      left_r <= len;
    else if (left_r != 8'h00)
      left_r <= left_r - 8'h01;
  end
  // long contact stands for an empty hopper, short for a full one
  assign contact = (left_r != 8'h00);
endmodule : clm_sensor_model
`default_nettype wire

// ### dv/clm_monitor_tb.sv
// self-checking bench of the consumable life monitor
`timescale 1ns/100ps
`default_nettype none

module clm_monitor_tb;
  logic sys_clk, rst, contact, drum_running, cover_closed, tick, pp;
  logic dot_valid, nvm_load, go, low, msg, empty, alarm, used_wr;
  logic drum_warn, belt_warn, fuser_warn;
  logic [2:0] fuse_ok, unit_new, fuse_blow;
  logic [15:0] dot_count, nvm_in, used, drum_life, belt_life, fuser_life;
  logic [7:0] len;
  int err_count, num_checks, cycles;

  clm_sensor_model u_clm_sensor_model (.sys_clk(sys_clk), .go(go),
    .len(len), .contact(contact));
  clm_monitor #(.STUCK_PERIOD_CYC(26'h14), .BLOW_CYC(18'h5),
    .CONTACT_LOW_CYC(24'h8)) u_clm_monitor (
    .sys_clk(sys_clk), .rst(rst), .toner_contact(contact),
    .drum_running(drum_running), .cover_closed(cover_closed),
    .unit_fuse_ok(fuse_ok), .drum_page_tick(tick), .page_passed(pp),
    .dot_valid(dot_valid), .dot_count(dot_count), .nvm_load(nvm_load),
    .nvm_used_in(nvm_in), .toner_low(low), .toner_low_msg(msg),
    .toner_empty(empty), .toner_sensor_alarm(alarm), .toner_used(used),
    .toner_used_wr(used_wr), .unit_new(unit_new), .fuse_blow(fuse_blow),
    .drum_life(drum_life), .belt_life(belt_life), .fuser_life(fuser_life),
    .drum_warn(drum_warn), .belt_warn(belt_warn), .fuser_warn(fuser_warn));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic conclude;
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // hang guard: the whole sequence needs about 62000 cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      err_count++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic smp(input logic [7:0] n);
    @(posedge sys_clk);
    go <= 1'b1;
    len <= n;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (n + 8'h05) @(posedge sys_clk);
  endtask : smp

  task automatic lows(input int n);
    repeat (n) smp(8'h0c);
  endtask : lows

  task automatic dot1;
    @(posedge sys_clk);
    dot_valid <= 1'b1;
    dot_count <= 16'hffff;
    @(posedge sys_clk);
    dot_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : dot1

  task automatic dots_to(input logic [15:0] exp);
    for (int k = 0; k < 20 && used !== exp; k++)
      dot1();
    @(negedge sys_clk);
    chk(used, exp);
  endtask : dots_to

  task automatic load(input logic [15:0] v);
    @(posedge sys_clk);
    nvm_load <= 1'b1;
    nvm_in <= v;
    @(posedge sys_clk);
    nvm_load <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : load

  initial
  begin
    {rst, drum_running, cover_closed, fuse_ok} = 6'h3d;
    {tick, pp, dot_valid, nvm_load, go} = 5'h00;
    {dot_count, nvm_in, len} = 40'h0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(unit_new, 3'b101);
    chk(fuse_blow, 3'b101);
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(fuse_blow, 3'b000);
    repeat (10) dot1();
    @(negedge sys_clk);
    chk(used, 16'h0000);
    smp(8'h03);
    repeat (300) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(alarm, 1'b0);
    repeat (30) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(alarm, 1'b1);
    lows(19);
    smp(8'h03);
    lows(19);
    drum_running <= 1'b0;
    smp(8'h03);
    drum_running <= 1'b1;
    @(negedge sys_clk);
    chk(low, 1'b0);
    chk(alarm, 1'b0);
    lows(1);
    @(negedge sys_clk);
    chk(low, 1'b1);
    chk(used, 16'h2cec);
    repeat (9) smp(8'h03);
    @(negedge sys_clk);
    chk(low, 1'b1);
    smp(8'h03);
    @(negedge sys_clk);
    chk(low, 1'b0);
    chk(used, 16'h0000);
    dots_to(16'h0001);
    lows(20);
    load(16'h2edf);
    chk(msg, 1'b0);
    dots_to(16'h2ee0);
    @(negedge sys_clk);
    chk(msg, 1'b1);
    load(16'h30d3);
    chk(empty, 1'b0);
    dots_to(16'h30d4);
    @(negedge sys_clk);
    chk(empty, 1'b1);
    @(posedge sys_clk);
    {tick, pp} <= 2'b11;
    repeat (19999) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(drum_warn, 1'b0);
    @(posedge sys_clk);
    {tick, pp} <= 2'b00;
    @(posedge sys_clk);
    pp <= 1'b1;
    repeat (39999) @(posedge sys_clk);
    @(posedge sys_clk);
    pp <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({drum_life, drum_warn}, {16'h4e20, 1'b1});
    chk({belt_life, belt_warn}, {16'hea60, 1'b1});
    chk({fuser_life, fuser_warn}, {16'hea60, 1'b1});
    @(posedge sys_clk);
    cover_closed <= 1'b0;
    @(posedge sys_clk);
    cover_closed <= 1'b1;
    fuse_ok <= 3'b010;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(unit_new, 3'b010);
    chk({belt_life, belt_warn}, 17'h0);
    chk(drum_warn, 1'b1);
    conclude();
  end
endmodule : clm_monitor_tb
`default_nettype wire
